// *** hdl/sda_afc_loop.sv ***
// Automatic frequency correction loop with gear, cycle length and freeze
`timescale 1ns/100ps
`default_nettype none
`include "sda_regs.svh"
module sda_afc_loop (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic multi_packet,
  input wire logic [2:0] gear,
  input wire logic [2:0] cycle_len,
  input wire logic [7:0] limit,
  // Modem
  input wire logic bit_tick,
  input wire logic signed [7:0] freq_err,
  input wire logic preamble_det,
  input wire logic packet_end,
  // Output
  output logic signed [7:0] corr
);
  import sda_pkg::*;
  sda_afc_state_e state;
  logic [3:0] bit_cnt;
  logic signed [9:0] err_sum;
  logic signed [9:0] meas_sum;
  logic frozen;
  logic signed [9:0] step;
  logic signed [10:0] next_corr;
  logic signed [10:0] lim;
  function automatic logic signed [10:0] clamp(input logic signed [10:0] v,
                                                input logic signed [10:0] l);
    if (v > l) clamp = l;
    else if (v < -l) clamp = -l;
    else clamp = v;
  endfunction : clamp
  assign lim = (limit > 8'h7F) ? 11'sd127 : $signed({3'b000, limit});
  // both measuring bits feed the step
  assign meas_sum = err_sum + 10'(freq_err);
  assign step = (meas_sum >>> 1) >>> gear;
  assign next_corr = clamp(11'(corr) + 11'(step), lim);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) frozen <= 1'b0;
    else if (!run) frozen <= 1'b0;
    // A preamble in the packet-end cycle wins over the clear
    else if (preamble_det) frozen <= 1'b1;
    else if (packet_end) frozen <= 1'b0;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= AFC_IDLE;
      bit_cnt <= 4'h0;
      err_sum <= 10'sd0;
      corr <= 8'sd0;
    end else if (!run) begin
      state <= AFC_IDLE;
      bit_cnt <= 4'h0;
      err_sum <= 10'sd0;
      corr <= 8'sd0;
    end else if (packet_end && multi_packet) begin
      state <= AFC_MEAS;
      bit_cnt <= 4'h0;
      err_sum <= 10'sd0;
      corr <= 8'sd0;
    end else if (bit_tick) begin
      case (state)
        AFC_IDLE: begin
          state <= AFC_MEAS;
          bit_cnt <= 4'h0;
          err_sum <= 10'sd0;
        end
        AFC_MEAS: begin
          if (bit_cnt == 4'(`SDA_MEAS_BITS - 1)) begin
            if (cycle_len != 3'b000 && !frozen) corr <= next_corr[7:0];
            bit_cnt <= 4'h0;
            state <= (cycle_len == 3'b000) ? AFC_MEAS : AFC_SETTLE;
            err_sum <= 10'sd0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            err_sum <= err_sum + 10'(freq_err);
          end
        end
        AFC_SETTLE: begin
          if (bit_cnt == {cycle_len, 1'b0} - 4'h1) begin
            bit_cnt <= 4'h0;
            err_sum <= 10'sd0;
            state <= AFC_MEAS;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default: state <= AFC_IDLE;
      endcase
    end
  end
  property p_afc_freeze;
    @(posedge core_clk) disable iff (rst)
      frozen && run && !packet_end |=> $stable(corr);
  endproperty
  a_afc_freeze: assert property (p_afc_freeze) else $error("correction moved after freeze");
  property p_afc_mpk;
    @(posedge core_clk) disable iff (rst) run && packet_end && multi_packet |=> corr == 8'sd0;
  endproperty
  a_afc_mpk: assert property (p_afc_mpk) else $error("correction not cleared at packet end");
  property p_afc_limit;
    @(posedge core_clk) disable iff (rst)
      $changed(corr) |-> 11'(corr) <= $past(lim) && 11'(corr) >= -$past(lim);
  endproperty
  a_afc_limit: assert property (p_afc_limit) else $error("correction beyond pull-in limit");
  property p_afc_nocycle;
    @(posedge core_clk) disable iff (rst)
      run && cycle_len == 3'b000 && !packet_end ##1 run && cycle_len == 3'b000 |-> $stable(corr);
  endproperty
  a_afc_nocycle: assert property (p_afc_nocycle) else $error("correction with zero cycle");
  c_afc_step: cover property (@(posedge core_clk) disable iff (rst) $changed(corr) && run);
  c_afc_frozen: cover property (@(posedge core_clk) disable iff (rst) $rose(frozen));
endmodule : sda_afc_loop
`default_nettype wire

// *** hdl/sda_pkg.sv ***
// Types shared by the synthesizer deviation, correction and rate logic
`default_nettype none
package sda_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sda_reg_req_s;
  typedef enum logic [1:0] {
    AFC_IDLE,
    AFC_MEAS,
    AFC_SETTLE
  } sda_afc_state_e;
  typedef logic signed [13:0] sda_frac_t;
endpackage : sda_pkg
`default_nettype wire

// *** hdl/sda_rate_gen.sv ***
// Transmit bit rate generator driven by a 1 MHz reference enable
`timescale 1ns/100ps
`default_nettype none
`include "sda_regs.svh"
module sda_rate_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic scale,
  input wire logic [15:0] rate_word,
  // Output
  output logic bit_tick
);
  import sda_pkg::*;
  logic [6:0] ref_cnt;
  logic ref_tick;
  logic [20:0] acc;
  logic [21:0] sum;
  assign sum = {1'b0, acc} + {6'h00, rate_word};
  // Divider that yields the 1 MHz reference enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_cnt <= 7'h00;
      ref_tick <= 1'b0;
    end else if (ref_cnt == 7'(`SDA_REF_DIV - 1)) begin
      ref_cnt <= 7'h00;
      ref_tick <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + 7'h01;
      ref_tick <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc <= 21'h000000;
      bit_tick <= 1'b0;
    end else if (!enable) begin
      acc <= 21'h000000;
      bit_tick <= 1'b0;
    end else if (ref_tick) begin
      if (scale) begin
        acc <= sum[20:0];
        bit_tick <= sum[21];
      end else begin
        acc <= {5'h00, sum[15:0]};
        bit_tick <= sum[16];
      end
    end else begin
      bit_tick <= 1'b0;
    end
  end
  property p_rate_idle;
    @(posedge core_clk) disable iff (rst) !enable |=> !bit_tick;
  endproperty
  a_rate_idle: assert property (p_rate_idle) else $error("bit tick outside transmit");
  property p_rate_ref;
    @(posedge core_clk) disable iff (rst) bit_tick |-> $past(ref_tick) && $past(enable);
  endproperty
  a_rate_ref: assert property (p_rate_ref) else $error("bit tick without reference");
  c_rate_tick: cover property (@(posedge core_clk) disable iff (rst) bit_tick);
endmodule : sda_rate_gen
`default_nettype wire

// *** hdl/sda_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SDA_REGS_SVH
`define SDA_REGS_SVH
`define SDA_ADDR_OP_CTRL 7'h08
`define SDA_ADDR_PULL_IN_LIMIT 7'h2A
`define SDA_ADDR_CORR_READBACK 7'h2B
`define SDA_ADDR_MODEM_TUNING 7'h58
`define SDA_ADDR_RATE_HIGH 7'h6E
`define SDA_ADDR_RATE_LOW 7'h6F
`define SDA_ADDR_MOD_CTRL_TWO 7'h71
`define SDA_ADDR_DEV_LOW 7'h72
`define SDA_ADDR_OFFSET_LOW 7'h73
`define SDA_ADDR_OFFSET_HIGH 7'h74
`define SDA_RST_OP_CTRL 8'h00
`define SDA_RST_PULL_IN_LIMIT 8'h00
`define SDA_RST_MODEM_TUNING 8'h80
`define SDA_RST_RATE_HIGH 8'h0A
`define SDA_RST_RATE_LOW 8'h3D
`define SDA_RST_MOD_CTRL_TWO 8'h00
`define SDA_RST_DEV_LOW 8'h20
`define SDA_RST_OFFSET_LOW 8'h00
`define SDA_RST_OFFSET_HIGH 8'h00
`define SDA_BIT_MULTI_PACKET 4
`define SDA_BIT_DEV_TOP 2
`define SDA_BIT_INVERT 3
`define SDA_CLK_PERIOD_NS 10
`define SDA_REF_PERIOD_NS 1000
`define SDA_REF_DIV (`SDA_REF_PERIOD_NS / `SDA_CLK_PERIOD_NS)
`define SDA_MEAS_BITS 2
`endif

// *** hdl/sda_synth_ctrl.sv ***
// Deviation, offset, correction and transmit rate control of the synthesizer
`timescale 1ns/100ps
`default_nettype none
`include "sda_regs.svh"
module sda_synth_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access
  input wire sda_pkg::sda_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Operating state and loose control bits
  input wire logic tx_mode,
  input wire logic rx_mode,
  input wire logic afc_enable,
  input wire logic hbsel,
  input wire logic rate_scale,
  input wire logic [2:0] afc_gear,
  input wire logic [2:0] afc_cycle_len,
  // Receive modem
  input wire logic rx_bit_tick,
  input wire logic signed [7:0] freq_err,
  input wire logic preamble_det,
  input wire logic packet_end,
  // Transmit data pin
  input wire logic tx_data_pin,
  // Synthesizer and modem outputs
  output sda_pkg::sda_frac_t synth_frac_adj,
  output logic tx_bit_tick,
  output logic [7:0] modem_tuning,
  output logic rx_multi_packet
);
  import sda_pkg::*;
  localparam logic [7:0] rst_op_ctrl = `SDA_RST_OP_CTRL;
  localparam logic [7:0] rst_mod_ctrl_two = `SDA_RST_MOD_CTRL_TWO;
  localparam logic [7:0] rst_offset_high = `SDA_RST_OFFSET_HIGH;
  logic [7:0] pull_in_limit_value;
  logic [15:0] rate_word;
  logic [7:0] mod_ctrl;
  logic [8:0] peak_deviation_word;
  logic [9:0] manual_offset_word;
  logic signed [7:0] afc_corr;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic tx_data_q;
  logic fsk_active;
  logic use_afc;
  sda_frac_t off_term;
  sda_frac_t dev_term;
  sda_frac_t next_frac;

  function automatic logic wr_hit(input sda_reg_req_s r, input logic [6:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  function automatic sda_frac_t sext10(input logic [9:0] v);
    sext10 = {{4{v[9]}}, v};
  endfunction : sext10

  function automatic sda_frac_t sext8(input logic [7:0] v);
    sext8 = {{6{v[7]}}, v};
  endfunction : sext8

  // Register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pull_in_limit_value <= `SDA_RST_PULL_IN_LIMIT;
    end else if (wr_hit(reg_req, `SDA_ADDR_PULL_IN_LIMIT)) begin
      pull_in_limit_value <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modem_tuning <= `SDA_RST_MODEM_TUNING;
    end else if (wr_hit(reg_req, `SDA_ADDR_MODEM_TUNING)) begin
      modem_tuning <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_multi_packet <= rst_op_ctrl[`SDA_BIT_MULTI_PACKET];
    end else if (wr_hit(reg_req, `SDA_ADDR_OP_CTRL)) begin
      rx_multi_packet <= reg_req.wdata[`SDA_BIT_MULTI_PACKET];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_word <= {`SDA_RST_RATE_HIGH, `SDA_RST_RATE_LOW};
    end else if (wr_hit(reg_req, `SDA_ADDR_RATE_HIGH)) begin
      rate_word[15:8] <= reg_req.wdata;
    end else if (wr_hit(reg_req, `SDA_ADDR_RATE_LOW)) begin
      rate_word[7:0] <= reg_req.wdata;
    end
  end

  // deviation word split over two registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mod_ctrl <= `SDA_RST_MOD_CTRL_TWO;
      peak_deviation_word <= {rst_mod_ctrl_two[`SDA_BIT_DEV_TOP], `SDA_RST_DEV_LOW};
    end else if (wr_hit(reg_req, `SDA_ADDR_MOD_CTRL_TWO)) begin
      mod_ctrl <= reg_req.wdata;
      peak_deviation_word[8] <= reg_req.wdata[`SDA_BIT_DEV_TOP];
    end else if (wr_hit(reg_req, `SDA_ADDR_DEV_LOW)) begin
      peak_deviation_word[7:0] <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      manual_offset_word <= {rst_offset_high[1:0], `SDA_RST_OFFSET_LOW};
    end else if (wr_hit(reg_req, `SDA_ADDR_OFFSET_LOW)) begin
      manual_offset_word[7:0] <= reg_req.wdata;
    end else if (wr_hit(reg_req, `SDA_ADDR_OFFSET_HIGH)) begin
      manual_offset_word[9:8] <= reg_req.wdata[1:0];
    end
  end

  // Register reads; unmapped addresses read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `SDA_ADDR_OP_CTRL: reg_rdata <= {3'b000, rx_multi_packet, 4'h0};
        `SDA_ADDR_PULL_IN_LIMIT: reg_rdata <= pull_in_limit_value;
        `SDA_ADDR_CORR_READBACK: reg_rdata <= afc_corr;
        `SDA_ADDR_MODEM_TUNING: reg_rdata <= modem_tuning;
        `SDA_ADDR_RATE_HIGH: reg_rdata <= rate_word[15:8];
        `SDA_ADDR_RATE_LOW: reg_rdata <= rate_word[7:0];
        `SDA_ADDR_MOD_CTRL_TWO: reg_rdata <= mod_ctrl;
        `SDA_ADDR_DEV_LOW: reg_rdata <= peak_deviation_word[7:0];
        `SDA_ADDR_OFFSET_LOW: reg_rdata <= manual_offset_word[7:0];
        `SDA_ADDR_OFFSET_HIGH: reg_rdata <= {6'h00, manual_offset_word[9:8]};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Transmit data pin synchroniser; accepted once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= tx_data_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_data_q <= 1'b0;
    end else if (pin_s2 == pin_s3) begin
      tx_data_q <= pin_s3 ^ mod_ctrl[`SDA_BIT_INVERT];
    end
  end

  // Frequency modulation only for the FSK and GFSK types
  assign fsk_active = tx_mode && mod_ctrl[1];
  // manual offset yields to automatic correction in receive only, never while transmitting
  assign use_afc = afc_enable && rx_mode && !tx_mode;
  assign off_term = use_afc ? sext8(afc_corr) : sext10(manual_offset_word);
  // 625 Hz steps in any band
  // low band halves after the loop
  assign dev_term = hbsel ? sda_frac_t'({peak_deviation_word, 1'b0})
                          : sda_frac_t'({peak_deviation_word, 2'b00});

  always_comb begin
    next_frac = off_term;
    if (fsk_active) begin
      if (tx_data_q) next_frac = off_term + dev_term;
      else next_frac = off_term - dev_term;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) synth_frac_adj <= 14'sd0;
    else synth_frac_adj <= next_frac;
  end

  sda_rate_gen u_rate (
    .core_clk(core_clk),
    .rst(rst),
    .enable(tx_mode),
    .scale(rate_scale),
    .rate_word(rate_word),
    .bit_tick(tx_bit_tick)
  );

  sda_afc_loop u_afc (
    .core_clk(core_clk),
    .rst(rst),
    .run(use_afc),
    .multi_packet(rx_multi_packet),
    .gear(afc_gear),
    .cycle_len(afc_cycle_len),
    .limit(pull_in_limit_value),
    .bit_tick(rx_bit_tick),
    .freq_err(freq_err),
    .preamble_det(preamble_det),
    .packet_end(packet_end),
    .corr(afc_corr)
  );

  property p_dev_swing;
    @(posedge core_clk) disable iff (rst)
      fsk_active && !use_afc && $stable(manual_offset_word) && $stable(tx_data_q)
      |=> synth_frac_adj - sext10($past(manual_offset_word))
          == ($past(tx_data_q) ? $past(dev_term) : -$past(dev_term));
  endproperty
  a_dev_swing: assert property (p_dev_swing) else $error("deviation step wrong");

  property p_dev_top;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_MOD_CTRL_TWO)
      |=> peak_deviation_word[8] == $past(reg_req.wdata[`SDA_BIT_DEV_TOP]);
  endproperty
  a_dev_top: assert property (p_dev_top) else $error("deviation top bit not taken");

  property p_offset_manual;
    @(posedge core_clk) disable iff (rst)
      !afc_enable && !fsk_active ##1 !afc_enable && !fsk_active && $stable(manual_offset_word)
      |=> synth_frac_adj == sext10($past(manual_offset_word, 2));
  endproperty
  a_offset_manual: assert property (p_offset_manual) else $error("manual offset not used");

  property p_tx_offset;
    @(posedge core_clk) disable iff (rst)
      tx_mode && !mod_ctrl[1] |=> synth_frac_adj == sext10($past(manual_offset_word));
  endproperty
  a_tx_offset: assert property (p_tx_offset) else $error("transmit not on offset word");

  property p_rx_afc;
    @(posedge core_clk) disable iff (rst)
      afc_enable && rx_mode && !tx_mode |=> synth_frac_adj == sext8($past(afc_corr));
  endproperty
  a_rx_afc: assert property (p_rx_afc) else $error("receive not on correction");

  property p_readback;
    @(posedge core_clk) disable iff (rst)
      reg_req.rd && reg_req.addr == `SDA_ADDR_CORR_READBACK |=> reg_rdata == $past(afc_corr);
  endproperty
  a_readback: assert property (p_readback) else $error("correction readback wrong");

  property p_mpk_bit;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_OP_CTRL)
      |=> rx_multi_packet == $past(reg_req.wdata[`SDA_BIT_MULTI_PACKET]);
  endproperty
  a_mpk_bit: assert property (p_mpk_bit) else $error("multi-packet bit not taken");

  property p_tick_tx_only;
    @(posedge core_clk) disable iff (rst) tx_bit_tick |-> $past(tx_mode);
  endproperty
  a_tick_tx_only: assert property (p_tick_tx_only) else $error("rate tick in receive");

  property p_rate_high;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_RATE_HIGH) |=> rate_word[15:8] == $past(reg_req.wdata);
  endproperty
  a_rate_high: assert property (p_rate_high) else $error("rate high byte not taken");

  property p_rate_low;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_RATE_LOW) |=> rate_word[7:0] == $past(reg_req.wdata);
  endproperty
  a_rate_low: assert property (p_rate_low) else $error("rate low byte not taken");

  property p_offset_low;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_OFFSET_LOW) |=> manual_offset_word[7:0] == $past(reg_req.wdata);
  endproperty
  a_offset_low: assert property (p_offset_low) else $error("offset low byte not taken");

  property p_offset_high;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_OFFSET_HIGH)
      |=> manual_offset_word[9:8] == $past(reg_req.wdata[1:0]);
  endproperty
  a_offset_high: assert property (p_offset_high) else $error("offset top bits not taken");

  property p_dev_low;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_DEV_LOW) |=> peak_deviation_word[7:0] == $past(reg_req.wdata);
  endproperty
  a_dev_low: assert property (p_dev_low) else $error("deviation low byte not taken");

  property p_limit_wr;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_PULL_IN_LIMIT) |=> pull_in_limit_value == $past(reg_req.wdata);
  endproperty
  a_limit_wr: assert property (p_limit_wr) else $error("pull-in limit not taken");

  property p_tuning_wr;
    @(posedge core_clk) disable iff (rst)
      wr_hit(reg_req, `SDA_ADDR_MODEM_TUNING) |=> modem_tuning == $past(reg_req.wdata);
  endproperty
  a_tuning_wr: assert property (p_tuning_wr) else $error("modem tuning not taken");

  c_fsk_swing: cover property (@(posedge core_clk) disable iff (rst)
    fsk_active && tx_data_q ##1 fsk_active && !tx_data_q);
  c_rx_afc: cover property (@(posedge core_clk) disable iff (rst) use_afc && afc_corr != 8'sd0);
endmodule : sda_synth_ctrl
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the synthesizer deviation, offset, correction and rate control
`timescale 1ns/100ps
`default_nettype none
`include "sda_regs.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import sda_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  sda_reg_req_s reg_req = '0;
  logic [7:0] reg_rdata;
  logic tx_mode = 1'b0, rx_mode = 1'b0, afc_enable = 1'b0, hbsel = 1'b1, rate_scale = 1'b0;
  logic [2:0] afc_gear = 3'h0, afc_cycle_len = 3'h1;
  logic rx_bit_tick = 1'b0, preamble_det = 1'b0, packet_end = 1'b0, tx_data_pin = 1'b0;
  logic signed [7:0] freq_err = 8'sh00;
  sda_frac_t synth_frac_adj;
  logic tx_bit_tick, rx_multi_packet;
  logic [7:0] modem_tuning, d, v;
  logic [9:0] off;
  logic [8:0] fd;
  logic [1:0] mt;
  logic inv;
  int mismatches = 0, n_compared = 0, cycles = 0, nt;
  logic [6:0] addr_tab [0:8] = '{7'h2A, 7'h58, 7'h6E, 7'h6F, 7'h71, 7'h72, 7'h73, 7'h74, 7'h08};
  logic [7:0] rst_tab [0:8] = '{8'h00, 8'h80, 8'h0A, 8'h3D, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  logic [7:0] mask_tab [0:8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h10};
  logic [9:0] off_tab [0:5] = '{10'h1FF, 10'h200, 10'h0A0, 10'h360, 10'h3FF, 10'h001};

  sda_synth_ctrl u_sda_synth_ctrl (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .tx_mode(tx_mode), .rx_mode(rx_mode), .afc_enable(afc_enable),
    .hbsel(hbsel), .rate_scale(rate_scale), .afc_gear(afc_gear), .afc_cycle_len(afc_cycle_len),
    .rx_bit_tick(rx_bit_tick), .freq_err(freq_err), .preamble_det(preamble_det),
    .packet_end(packet_end), .tx_data_pin(tx_data_pin), .synth_frac_adj(synth_frac_adj),
    .tx_bit_tick(tx_bit_tick), .modem_tuning(modem_tuning), .rx_multi_packet(rx_multi_packet));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] w);
    @(negedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(negedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    @(negedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    reg_req.rd <= 1'b0;
    @(negedge core_clk);
    q = reg_rdata;
  endtask : rd

  task automatic tick(input logic signed [7:0] e);
    @(negedge core_clk);
    freq_err <= e;
    rx_bit_tick <= 1'b1;
    @(negedge core_clk);
    rx_bit_tick <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : tick

  // Fresh loop start, three bit ticks, then readback and synthesizer word
  task automatic afc_case(input logic [2:0] g, input logic [2:0] len, input logic [7:0] lim,
                          input logic signed [7:0] e, input logic [7:0] exp);
    wr(7'h2A, lim);
    afc_enable <= 1'b0;
    repeat (2) @(negedge core_clk);
    afc_gear <= g;
    afc_cycle_len <= len;
    afc_enable <= 1'b1;
    repeat (2) @(negedge core_clk);
    repeat (3) tick(e);
    rd(`SDA_ADDR_CORR_READBACK, d);
    `CHK("correction readback", exp, d)
    `CHK("frac from correction", sda_frac_t'({{6{exp[7]}}, exp}), synth_frac_adj)
  endtask : afc_case

  function automatic sda_frac_t exp_frac(input logic [9:0] o, input logic [8:0] f,
                                         input logic hb, input logic fsk, input logic up);
    sda_frac_t s, dv;
    s = {{4{o[9]}}, o};
    dv = hb ? {4'h0, f, 1'b0} : {3'h0, f, 2'b00};
    if (!fsk) dv = '0;
    return up ? s + dv : s - dv;
  endfunction : exp_frac

  initial begin
    void'($urandom(85));
    repeat (8) @(negedge core_clk);
    rst <= 1'b0;
    `CHK("tuning after reset", 8'h80, modem_tuning)
    for (int i = 0; i < 9; i++) begin
      rd(addr_tab[i], d);
      `CHK("reset value", rst_tab[i], d)
    end
    for (int i = 0; i < 9; i++) begin
      v = 8'($urandom);
      wr(addr_tab[i], v);
      rd(addr_tab[i], d);
      `CHK("read back", v & mask_tab[i], d)
    end
    wr(7'h2B, 8'h55);
    rd(7'h2B, d);
    `CHK("read-only readback", 8'h00, d)
    wr(7'h10, 8'h77);
    rd(7'h10, d);
    `CHK("unmapped read", 8'h00, d)
    wr(7'h58, 8'hC0);
    `CHK("tuning output", 8'hC0, modem_tuning)
    wr(7'h71, 8'h00);
    for (int i = 0; i < 10; i++) begin
      off = (i < 6) ? off_tab[i] : 10'($urandom);
      hbsel <= i[0];
      wr(7'h73, off[7:0]);
      wr(7'h74, {6'h00, off[9:8]});
      repeat (3) @(negedge core_clk);
      `CHK("manual offset", exp_frac(off, 9'h000, 1'b0, 1'b0, 1'b1), synth_frac_adj)
    end
    wr(7'h73, 8'h05);
    wr(7'h74, 8'h00);
    rx_mode <= 1'b1;
    afc_case(3'h0, 3'h1, 8'd100, 8'sd20, 8'h14);
    afc_case(3'h1, 3'h1, 8'd100, 8'sd40, 8'h14);
    afc_case(3'h0, 3'h1, 8'd3, 8'sd100, 8'h03);
    afc_case(3'h0, 3'h0, 8'd100, 8'sd20, 8'h00);
    afc_case(3'h0, 3'h1, 8'd100, -8'sd20, 8'hEC);
    @(negedge core_clk);
    preamble_det <= 1'b1;
    @(negedge core_clk);
    preamble_det <= 1'b0;
    repeat (6) tick(8'sd60);
    rd(7'h2B, d);
    `CHK("frozen correction", 8'hEC, d)
    wr(7'h08, 8'h10);
    `CHK("multi packet bit", 1'b1, rx_multi_packet)
    @(negedge core_clk);
    packet_end <= 1'b1;
    @(negedge core_clk);
    packet_end <= 1'b0;
    rd(7'h2B, d);
    `CHK("cleared at packet end", 8'h00, d)
    afc_case(3'h0, 3'h1, 8'd100, 8'sd20, 8'h14);
    rx_mode <= 1'b0;
    tx_mode <= 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK("transmit uses offset", exp_frac(10'h005, 9'h0, 1'b0, 1'b0, 1'b1), synth_frac_adj)
    afc_enable <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      fd = (i == 0) ? 9'h1FF : 9'($urandom);
      mt = 2'(i);
      inv = 1'($urandom);
      hbsel <= i[2];
      tx_data_pin <= 1'($urandom);
      wr(7'h72, fd[7:0]);
      wr(7'h71, {4'h0, inv, fd[8], mt});
      repeat (8) @(negedge core_clk);
      `CHK("deviation", exp_frac(10'h005, fd, i[2], mt[1], tx_data_pin ^ inv), synth_frac_adj)
    end
    tx_data_pin <= ~tx_data_pin;
    repeat (8) @(negedge core_clk);
    `CHK("deviation swing", exp_frac(10'h005, fd, hbsel, 1'b1, tx_data_pin ^ inv), synth_frac_adj)
    wr(7'h6E, 8'h80);
    wr(7'h6F, 8'h00);
    for (int s = 0; s < 2; s++) begin
      tx_mode <= 1'b0;
      rate_scale <= s[0];
      repeat (4) @(negedge core_clk);
      tx_mode <= 1'b1;
      nt = 0;
      repeat (s ? 13000 : 4050) begin
        @(negedge core_clk);
        if (tx_bit_tick === 1'b1) nt++;
      end
      `CHK("rate tick count", s ? 2 : 20, nt)
    end
    tx_mode <= 1'b0;
    nt = 0;
    repeat (600) begin
      @(negedge core_clk);
      if (tx_bit_tick === 1'b1) nt++;
    end
    `CHK("no ticks outside transmit", 0, nt)
    wrap_up();
  end
endmodule : tb
`default_nettype wire
